//--- core/smf_top.sv
// Serial front end: two-wire slave and async answer-to-reset sender
`timescale 1ns/10ps
module smf_top
#(
   parameter int WR_CYCLES = smf_pkg::WR_CYCLES
)
(
   input  wire logic        CLK_SYS,
   input  wire logic        RSTN,
   input  wire logic        LINK_CLK,
   input  wire logic        CARD_RST,
   input  wire logic        SDA_IN,
   output logic             SDA_OUT,
   output logic             SDA_OE_N,
   input  wire logic [3:0]  DEV_ADDR,
   input  wire logic [63:0] ATR_DATA,
   input  wire logic        AUTH_OK,
   input  wire logic [1:0]  KEY_SEL,
   input  wire logic [7:0]  ZONE_PW_OK,
   input  wire logic [7:0]  ZONE_WR_EN,
   output logic             ASYNC_MODE,
   output logic             WR_BUSY
);
   smf_mem_if mif ();

   logic [2:0]  scl_q, sda_q, rst_q;
   logic        scl_r, sda_r, rstp_r;
   logic        scl_rise, scl_fall, sda_fall, sda_rise, start_ev, stop_ev;
   smf_pkg::smf_state_e st_r;
   logic [7:0]  rx_sh_r, tx_sh_r, ks_r;
   logic [3:0]  bitcnt_r;
   logic [1:0]  idx_r;
   logic        rw_r, ack_r, wrote_r, drive_r;
   logic [2:0]  zone_r;
   logic [6:0]  off_r;
   logic [4:0]  pg_cnt_r;
   logic [15:0] busy_r;
   logic [8:0]  etu_r;
   logic [3:0]  abit_r;
   logic [2:0]  abyte_r;
   logic [7:0]  atr_byte, ks;
   logic        atr_bit, wr_ok;

   // Three-stage samplers; a level counts once stages two and three agree
   always_ff @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
      begin
         scl_q  <= 3'h7;
         sda_q  <= 3'h7;
         rst_q  <= 3'h7;
         scl_r  <= 1'b1;
         sda_r  <= 1'b1;
         rstp_r <= 1'b1;
      end
      else
      begin
         scl_q <= {scl_q[1:0], LINK_CLK};
         sda_q <= {sda_q[1:0], SDA_IN};
         rst_q <= {rst_q[1:0], CARD_RST};
         if (scl_q[1] == scl_q[2])
            scl_r <= scl_q[2];
         if (sda_q[1] == sda_q[2])
            sda_r <= sda_q[2];
         if (rst_q[1] == rst_q[2])
            rstp_r <= rst_q[2];
      end
   end

   always_comb
   begin
      scl_rise = (scl_q[1] == scl_q[2]) && scl_q[2] && !scl_r;
      scl_fall = (scl_q[1] == scl_q[2]) && !scl_q[2] && scl_r;
      sda_rise = (sda_q[1] == sda_q[2]) && sda_q[2] && !sda_r;
      sda_fall = (sda_q[1] == sda_q[2]) && !sda_q[2] && sda_r;
      start_ev = sda_fall && scl_r;
      stop_ev  = sda_rise && scl_r;
      ks       = AUTH_OK ? ks_r : 8'h00;
      atr_byte = ATR_DATA[{abyte_r, 3'h0} +: 8];
      wr_ok    = ZONE_PW_OK[zone_r] && ZONE_WR_EN[zone_r];
      // Level of the answer bit that follows bit abit_r: data, then even parity, then guard
      if (abit_r < 4'h8)
         atr_bit = atr_byte[abit_r[2:0]];
      else if (abit_r == 4'h8)
         atr_bit = ^atr_byte;
      else
         atr_bit = 1'b1;
   end

   // A low seen on the reset pin selects the async card link until system reset
   always_ff @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
         ASYNC_MODE <= 1'b0;
      else if (!rstp_r)
         ASYNC_MODE <= 1'b1;
   end

   // Internal write cycle timer, started by stop after a write
   always_ff @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
         busy_r <= 16'h0000;
      else if (stop_ev && wrote_r && st_r != smf_pkg::ST_ATR)
         busy_r <= 16'(WR_CYCLES);
      else if (busy_r != 16'h0000)
         busy_r <= busy_r - 16'h0001;
   end

   always_ff @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
         WR_BUSY <= 1'b0;
      else
         WR_BUSY <= (busy_r > 16'h0001);
   end

   always_ff @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
      begin
         st_r     <= smf_pkg::ST_IDLE;
         rx_sh_r  <= 8'h00;
         tx_sh_r  <= 8'h00;
         ks_r     <= smf_pkg::KS_SEED;
         bitcnt_r <= 4'h0;
         idx_r    <= 2'h0;
         rw_r     <= 1'b0;
         ack_r    <= 1'b0;
         wrote_r  <= 1'b0;
         drive_r  <= 1'b0;
         zone_r   <= 3'h0;
         off_r    <= 7'h00;
         pg_cnt_r <= 5'h00;
         etu_r    <= 9'h000;
         abit_r   <= 4'h0;
         abyte_r  <= 3'h0;
      end
      else if (ASYNC_MODE)
      begin
         if (!rstp_r)
         begin
            st_r    <= smf_pkg::ST_IDLE;
            drive_r <= 1'b0;
         end
         else if (st_r == smf_pkg::ST_IDLE)
         begin
            st_r    <= smf_pkg::ST_ATR;
            etu_r   <= 9'h000;
            abit_r  <= 4'h0;
            abyte_r <= 3'h0;
            drive_r <= 1'b1;
         end
         else if (st_r == smf_pkg::ST_ATR && scl_rise)
         begin
            if (etu_r == 9'(smf_pkg::ETU_CYCLES - 1))
            begin
               etu_r <= 9'h000;
               if (abit_r == 4'(smf_pkg::ATR_BITS - 1))
               begin
                  abit_r <= 4'h0;
                  if (abyte_r == 3'(smf_pkg::ATR_BYTES - 1))
                  begin
                     st_r    <= smf_pkg::ST_TX;   // Link left idle once the answer is out
                     drive_r <= 1'b0;
                  end
                  else
                  begin
                     abyte_r <= abyte_r + 3'h1;
                     drive_r <= 1'b1;
                  end
               end
               else
               begin
                  abit_r  <= abit_r + 4'h1;
                  drive_r <= !atr_bit;
               end
            end
            else
               etu_r <= etu_r + 9'h001;
         end
      end
      else if (start_ev)
      begin
         st_r     <= smf_pkg::ST_RX;
         bitcnt_r <= 4'h0;
         idx_r    <= 2'h0;
         wrote_r  <= 1'b0;
         drive_r  <= 1'b0;
         ks_r     <= {KEY_SEL, smf_pkg::KS_SEED[5:0]};
      end
      else if (stop_ev)
      begin
         st_r    <= smf_pkg::ST_IDLE;
         drive_r <= 1'b0;
      end
      else
      begin
         unique case (st_r)
            smf_pkg::ST_IDLE, smf_pkg::ST_ATR:
               drive_r <= 1'b0;
            smf_pkg::ST_RX:
            begin
               if (scl_rise)
               begin
                  rx_sh_r  <= {rx_sh_r[6:0], sda_r};
                  bitcnt_r <= bitcnt_r + 4'h1;
               end
               else if (scl_fall && bitcnt_r == 4'h8)
               begin
                  st_r    <= smf_pkg::ST_RACK;
                  drive_r <= 1'b1;
                  if (idx_r == 2'h0)
                  begin
                     if (rx_sh_r[7:4] != DEV_ADDR || busy_r != 16'h0000)
                     begin
                        st_r    <= smf_pkg::ST_IDLE;
                        drive_r <= 1'b0;
                     end
                     rw_r   <= rx_sh_r[0];
                     zone_r <= rx_sh_r[3:1];
                     idx_r  <= 2'h1;
                  end
                  else if (idx_r == 2'h1)
                  begin
                     off_r    <= rx_sh_r[6:0];
                     pg_cnt_r <= 5'h00;
                     idx_r    <= 2'h2;
                  end
                  else if (pg_cnt_r != 5'(smf_pkg::PAGE_BYTES) && wr_ok)
                  begin
                     off_r    <= {off_r[6:4], off_r[3:0] + 4'h1};
                     pg_cnt_r <= pg_cnt_r + 5'h01;
                     wrote_r  <= 1'b1;
                     ks_r     <= {ks_r[6:0], ^(ks_r & smf_pkg::KS_TAPS)};
                  end
               end
            end
            smf_pkg::ST_RACK:
               if (scl_fall)
               begin
                  bitcnt_r <= 4'h0;
                  if (rw_r && idx_r == 2'h1)
                  begin
                     st_r    <= smf_pkg::ST_TX;
                     tx_sh_r <= mif.rdata ^ ks;
                     drive_r <= !(mif.rdata[7] ^ ks[7]);
                  end
                  else
                  begin
                     st_r    <= smf_pkg::ST_RX;
                     drive_r <= 1'b0;
                  end
               end
            smf_pkg::ST_TX:
               if (scl_fall)
               begin
                  bitcnt_r <= bitcnt_r + 4'h1;
                  if (bitcnt_r == 4'h7)
                  begin
                     st_r    <= smf_pkg::ST_TACK;
                     drive_r <= 1'b0;
                  end
                  else
                  begin
                     tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                     drive_r <= !tx_sh_r[6];
                  end
               end
            smf_pkg::ST_TACK:
               if (scl_rise)
               begin
                  ack_r <= !sda_r;
                  off_r <= off_r + 7'h01;
                  ks_r  <= {ks_r[6:0], ^(ks_r & smf_pkg::KS_TAPS)};
               end
               else if (scl_fall)
               begin
                  bitcnt_r <= 4'h0;
                  if (ack_r)
                  begin
                     st_r    <= smf_pkg::ST_TX;
                     tx_sh_r <= mif.rdata ^ ks;
                     drive_r <= !(mif.rdata[7] ^ ks[7]);
                  end
                  else
                     st_r <= smf_pkg::ST_IDLE;
               end
            default:
               st_r <= smf_pkg::ST_IDLE;
         endcase
      end
   end

   // Open-drain pin: only low or released
   always_ff @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
      begin
         SDA_OUT  <= 1'b0;
         SDA_OE_N <= 1'b1;
      end
      else
      begin
         SDA_OUT  <= 1'b0;
         SDA_OE_N <= !drive_r;
      end
   end

   assign mif.addr  = {1'b0, zone_r, off_r};
   assign mif.wdata = rx_sh_r ^ ks;
   assign mif.we    = !ASYNC_MODE && !start_ev && !stop_ev && st_r == smf_pkg::ST_RX && scl_fall
                      && bitcnt_r == 4'h8 && idx_r == 2'h2 && wr_ok
                      && pg_cnt_r != 5'(smf_pkg::PAGE_BYTES);

   smf_mem u_mem
   (
      .clk (CLK_SYS),
      .mp  (mif)
   );
endmodule

//--- core/smf_pkg.sv
// Constants shared by the secure memory serial front end
// Contract
// - Async mode: every emitted bit lasts 372 carrier clock cycles.
// - Two-wire mode: incoming bits are sampled on the serial clock rising edge.
// - Two-wire mode: read data changes on the serial clock falling edge.
// - Async reset activation sends the eight-byte answer-to-reset register.
// - No answer-to-reset bytes are ever sent in two-wire mode.
// - Reset pin pulled high internally; left open means two-wire mode.
// - Data line is only pulled low or released; pull-up gives high.
// - Two-wire mode answers only its own address; sixteen addresses distinguishable.
// - User memory is eight zones of 128 bytes, each with own rights.
// - Writes are single byte or page up to 16; completed internally.
// - After authentication all exchanged data are stream encrypted.
// - Four key sets; any may be selected for authentication and encryption.
// - Eight password sets of two 24-bit passwords gate access. Here ZONE_PW_OK gates zone writes only; reads are not checked.
// - Configuration has a 37-byte OTP area and 160-byte key area.
// - Eight-bit words; device acknowledges each by pulling low on ninth clock.
package smf_pkg;
   localparam int ETU_CYCLES     = 372;
   localparam int ATR_BYTES      = 8;
   localparam int ATR_BITS       = 11;
   localparam int ZONES          = 8;
   localparam int ZONE_BYTES     = 128;
   localparam int PAGE_BYTES     = 16;
   localparam int USER_BYTES     = ZONES * ZONE_BYTES;
   localparam int CFG_OTP_BASE   = USER_BYTES;
   localparam int CFG_OTP_BYTES  = 37;
   localparam int CFG_KEY_BASE   = CFG_OTP_BASE + CFG_OTP_BYTES;
   localparam int CFG_KEY_BYTES  = 160;
   localparam int MEM_BYTES      = CFG_KEY_BASE + CFG_KEY_BYTES;
   localparam int MEM_AW         = 11;
   localparam int KEY_SETS       = 4;
   localparam int PW_SETS        = 8;
   localparam int PW_BITS        = 24;
   localparam int DEV_ADDR_BITS  = 4;
   localparam real CLK_NS        = 100.0;
   localparam real T_WR_MS       = 5.0;
   localparam int WR_CYCLES      = int'(T_WR_MS * 1.0e6 / CLK_NS);
   localparam logic [7:0] KS_SEED = 8'h2B;
   localparam logic [7:0] KS_TAPS = 8'hB8;
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RACK, ST_TX, ST_TACK, ST_ATR} smf_state_e;
endpackage

//--- core/smf_mem_if.sv
// Memory port between the serial engine and the storage array
`timescale 1ns/10ps
interface smf_mem_if;
   logic                        we;
   logic [smf_pkg::MEM_AW-1:0]  addr;
   logic [7:0]                  wdata;
   logic [7:0]                  rdata;
   modport ctl (output we, output addr, output wdata, input rdata);
   modport mem (input we, input addr, input wdata, output rdata);
endinterface

//--- core/smf_mem.sv
// User and configuration storage with registered read data
`timescale 1ns/10ps
module smf_mem
(
   input  wire logic   clk,
   smf_mem_if.mem      mp
);
   // User zones followed by OTP and key/password areas
   logic [7:0] arr [smf_pkg::MEM_BYTES];

   always_ff @(posedge clk)
   begin
      if (mp.we)
      begin
         arr[mp.addr] <= mp.wdata;
      end
      mp.rdata <= arr[mp.addr];
   end
endmodule

//--- verif/smf_host_bfm.sv
// Host model: bit-banged two-wire master, async carrier, pulled-up data wire
`timescale 1ns/10ps
module smf_host_bfm
(
   input  wire logic clk,
   input  wire logic dev_out,
   input  wire logic dev_oe_n,
   output logic      scl,
   output logic      sda
);
   localparam int PH = 10;
   logic host_sda = 1'b1;
   logic carrier  = 1'b0;
   // Open-drain wire with pull-up: each party only pulls low
   assign sda = host_sda & (dev_oe_n | dev_out);
   initial
   begin
      scl = 1'b1;
      #37;
      forever
      begin
         #400;
         if (carrier)
            scl = ~scl;
      end
   end
   task automatic tick();
      repeat (PH) @(posedge clk);
   endtask
   task automatic start_c();
      host_sda <= 1'b1;
      tick();
      scl <= 1'b1;
      tick();
      host_sda <= 1'b0;
      tick();
      scl <= 1'b0;
   endtask
   task automatic stop_c();
      tick();
      host_sda <= 1'b0;
      tick();
      scl <= 1'b1;
      tick();
      host_sda <= 1'b1;
      tick();
   endtask
   // Data moves only while the clock is low; the line is read at the end of high
   task automatic bit_x(input logic d, output logic q);
      tick();
      host_sda <= d;
      tick();
      scl <= 1'b1;
      tick();
      q = sda;
      scl <= 1'b0;
   endtask
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic q;
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], q);
      bit_x(1'b1, q);
      ack = !q;
   endtask
   task automatic get_byte(input logic last, output logic [7:0] d);
      logic q;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(1'b1, q);
         d[i] = q;
      end
      bit_x(last, q);
   endtask
endmodule

//--- verif/smf_top_chk.sv
// Pin-level checks for the serial front end
`timescale 1ns/10ps
module smf_top_chk
#(
   parameter int WR_CYCLES = smf_pkg::WR_CYCLES
)
(
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic LINK_CLK,
   input wire logic CARD_RST,
   input wire logic SDA_OUT,
   input wire logic SDA_OE_N,
   input wire logic ASYNC_MODE,
   input wire logic WR_BUSY
);
   localparam int ETU = smf_pkg::ETU_CYCLES;
   logic        lk_d;
   logic        oe_d;
   logic [12:0] etu_cnt;
   logic [1:0]  seen;
   logic [19:0] busy_cnt;
   always_ff @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
      begin
         lk_d <= 1'b1;
         oe_d <= 1'b1;
      end
      else
      begin
         lk_d <= LINK_CLK;
         oe_d <= SDA_OE_N;
      end
   end
   // Carrier rises since the last data line change
   always_ff @(posedge CLK_SYS or negedge RSTN)
      if (!RSTN) etu_cnt <= '0;
      else if (SDA_OE_N != oe_d) etu_cnt <= '0;
      else if (LINK_CLK && !lk_d) etu_cnt <= etu_cnt + 13'h1;
   // First bit starts off the carrier grid; only spans between later changes are timed
   always_ff @(posedge CLK_SYS or negedge RSTN)
      if (!RSTN) seen <= 2'h0;
      else if (ASYNC_MODE && SDA_OE_N != oe_d && seen != 2'h2) seen <= seen + 2'h1;
   always_ff @(posedge CLK_SYS or negedge RSTN)
      if (!RSTN) busy_cnt <= '0;
      else if (WR_BUSY) busy_cnt <= busy_cnt + 20'h1;
      else busy_cnt <= '0;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   sequence s_low_hold;
      !SDA_OE_N [*8];
   endsequence
   oe_low_only_a: assert property (SDA_OUT == 1'b0) else $error("data pin driven high");
   async_hold_a: assert property ($past(ASYNC_MODE) |-> ASYNC_MODE)
      else $error("async mode dropped");
   async_entry_a: assert property ($rose(ASYNC_MODE) |-> $past(CARD_RST, 3) == 1'b0)
      else $error("async mode without card reset low");
   etu_len_a: assert property (ASYNC_MODE && seen == 2'h2 && $changed(SDA_OE_N)
      |-> etu_cnt % ETU == 0 && etu_cnt != 13'h0) else $error("bit length wrong");
   tw_fall_a: assert property (!ASYNC_MODE && $changed(SDA_OE_N)
      |-> !LINK_CLK && $past(LINK_CLK, 2) == 1'b0) else $error("data changed in clock high");
   ack_hold_a: assert property (!ASYNC_MODE && $fell(SDA_OE_N) |-> s_low_hold)
      else $error("low drive too short");
   busy_len_a: assert property ($fell(WR_BUSY)
      |-> busy_cnt >= WR_CYCLES - 1 && busy_cnt <= WR_CYCLES) else $error("busy length wrong");
   busy_mode_a: assert property ($rose(WR_BUSY) |-> !ASYNC_MODE && LINK_CLK)
      else $error("busy without stop");
endmodule

//--- verif/tb.sv
// Self-checking bench for the serial front end
`timescale 1ns/10ps
module tb;
   localparam int WRC = 600;
   logic        clk_sys;
   logic        rstn;
   logic        card_rst;
   logic        link_clk;
   logic        sda;
   logic        sda_out;
   logic        sda_oe_n;
   logic        async_mode;
   logic        wr_busy;
   logic [3:0]  dev_addr;
   logic [63:0] atr_data;
   logic        auth_ok;
   logic [1:0]  key_sel;
   logic [7:0]  zone_pw_ok;
   logic [7:0]  zone_wr_en;
   logic [31:0] lfsr = 32'h45A0;
   logic [7:0]  dat [16];
   logic [7:0]  d;
   logic [2:0]  z;
   logic [6:0]  off;
   logic [10:0] fr;
   logic        ack;
   int          error_cnt = 0;
   int          num_checks = 0;
   smf_top #(.WR_CYCLES(WRC)) dut (.CLK_SYS(clk_sys), .RSTN(rstn), .LINK_CLK(link_clk),
      .CARD_RST(card_rst), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n),
      .DEV_ADDR(dev_addr), .ATR_DATA(atr_data), .AUTH_OK(auth_ok), .KEY_SEL(key_sel),
      .ZONE_PW_OK(zone_pw_ok), .ZONE_WR_EN(zone_wr_en), .ASYNC_MODE(async_mode),
      .WR_BUSY(wr_busy));
   smf_host_bfm host (.clk(clk_sys), .dev_out(sda_out), .dev_oe_n(sda_oe_n),
      .scl(link_clk), .sda(sda));
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Character frame: start 0, data LSB first, even parity, guard 1
   function automatic logic [10:0] frame(input logic [7:0] b);
      return {1'b1, ^b, b, 1'b0};
   endfunction
   // Keystream byte after n advances from the start seed
   function automatic logic [7:0] ks_at(input logic [1:0] k, input int n);
      logic [7:0] s;
      s = {k, smf_pkg::KS_SEED[5:0]};
      for (int j = 0; j < n; j++)
         s = {s[6:0], ^(s & smf_pkg::KS_TAPS)};
      return s;
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr_hdr();
      host.start_c();
      host.put_byte({dev_addr, z, 1'b0}, ack);
      check(ack, 1'b1);
      host.put_byte({1'b0, off}, ack);
      check(ack, 1'b1);
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   initial
   begin
      repeat (90000) @(posedge clk_sys);
      error_cnt++;
      wrap_up();
   end
   initial
   begin
      rstn = 1'b0;
      card_rst = 1'b1;
      auth_ok = 1'b0;
      zone_pw_ok = 8'hFF;
      zone_wr_en = 8'hFF;
      lfsr = lfsr_next(lfsr);
      dev_addr = lfsr[3:0];
      key_sel = lfsr[5:4];
      atr_data = {lfsr, lfsr_next(lfsr)};
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (5) @(posedge clk_sys);
      check(async_mode, 1'b0);
      for (int a = 0; a < 16; a++)
      begin
         host.start_c();
         host.put_byte({a[3:0], 4'h0}, ack);
         check(ack, a[3:0] == dev_addr);
         host.stop_c();
      end
      $display("address test done");
      for (int p = 0; p < 2; p++)
      begin
         lfsr = lfsr_next(lfsr);
         z = lfsr[2:0];
         off = {lfsr[6:4], 4'h0};
         auth_ok <= p[0];
         key_sel <= lfsr[9:8];
         for (int i = 0; i < 16; i++)
         begin
            lfsr = lfsr_next(lfsr);
            dat[i] = lfsr[7:0];
         end
         wr_hdr();
         for (int i = 0; i < 17; i++)
         begin
            host.put_byte(i < 16 ? dat[i] : ~dat[0], ack);
            check(ack, 1'b1);
         end
         host.stop_c();
         check(wr_busy, 1'b1);
         host.start_c();
         host.put_byte({dev_addr, z, 1'b0}, ack);
         check(ack, 1'b0);
         host.stop_c();
         for (int n = 0; n < 1000 && wr_busy !== 1'b0; n++)
            @(posedge clk_sys);
         check(wr_busy, 1'b0);
         if (p == 1)
         begin
            zone_wr_en[z] <= 1'b0;
            wr_hdr();
            host.put_byte(~dat[0], ack);
            check(ack, 1'b1);
            host.stop_c();
            check(wr_busy, 1'b0);
         end
         // Second read in the keyed pass comes back raw, exposing the stored keystream
         for (int r = 0; r <= p; r++)
         begin
            auth_ok <= p[0] && (r == 0);
            wr_hdr();
            host.start_c();
            host.put_byte({dev_addr, z, 1'b1}, ack);
            check(ack, 1'b1);
            for (int i = 0; i < 16; i++)
            begin
               host.get_byte(i == 15, d);
               check(d, r == 0 ? dat[i] : dat[i] ^ ks_at(key_sel, i));
            end
            host.stop_c();
         end
         check(async_mode, 1'b0);
         check(sda_oe_n, 1'b1);
         zone_wr_en <= 8'hFF;
         $display("write and read pass %0d done", p);
      end
      card_rst <= 1'b0;
      repeat (20) @(posedge clk_sys);
      check(async_mode, 1'b1);
      check(sda_oe_n, 1'b1);
      host.carrier = 1'b1;
      card_rst <= 1'b1;
      for (int n = 0; n < 2000 && sda_oe_n !== 1'b0; n++)
         @(posedge clk_sys);
      fr = frame(atr_data[7:0]);
      for (int b = 0; b < 11; b++)
      begin
         repeat (b == 0 ? 186 : 372) @(posedge link_clk);
         check(sda, fr[b]);
      end
      host.carrier = 1'b0;
      $display("answer test done");
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check(async_mode, 1'b0);
      check(sda_oe_n, 1'b1);
      rstn <= 1'b1;
      repeat (5) @(posedge clk_sys);
      wrap_up();
   end
endmodule
bind smf_top smf_top_chk #(.WR_CYCLES(WR_CYCLES)) u_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
   .LINK_CLK(LINK_CLK), .CARD_RST(CARD_RST), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N),
   .ASYNC_MODE(ASYNC_MODE), .WR_BUSY(WR_BUSY));
